// file: src/nbi_regs.svh
`ifndef NBI_REGS_SVH
`define NBI_REGS_SVH

// System clock period.
`define NBI_CLK_NS        10

// Strobe phase times, each a least time, so the cycle counts round up.
`define NBI_T_SETUP_NS    10
`define NBI_T_WLOW_NS     15
`define NBI_T_WHIGH_NS    10
// The read low phase also covers the access time plus two synchroniser stages.
`define NBI_T_RLOW_NS     50
`define NBI_T_RHIGH_NS    10
// Delay from the last write edge until the busy line is valid.
`define NBI_T_WB_NS       100

`define NBI_SETUP_CYC  ((`NBI_T_SETUP_NS + `NBI_CLK_NS - 1) / `NBI_CLK_NS)
`define NBI_WLOW_CYC   ((`NBI_T_WLOW_NS + `NBI_CLK_NS - 1) / `NBI_CLK_NS)
`define NBI_WHIGH_CYC  ((`NBI_T_WHIGH_NS + `NBI_CLK_NS - 1) / `NBI_CLK_NS)
`define NBI_RLOW_CYC   ((`NBI_T_RLOW_NS + `NBI_CLK_NS - 1) / `NBI_CLK_NS)
`define NBI_RHIGH_CYC  ((`NBI_T_RHIGH_NS + `NBI_CLK_NS - 1) / `NBI_CLK_NS)
`define NBI_WB_CYC     ((`NBI_T_WB_NS + `NBI_CLK_NS - 1) / `NBI_CLK_NS)

// Array geometry.
`define NBI_PAGE_MAIN_BYTES   2048
`define NBI_PAGE_SPARE_BYTES  64
`define NBI_PAGES_PER_BLOCK   64
`define NBI_BLOCKS            2048
`define NBI_COL_W             12
`define NBI_ROW_W             17
`define NBI_PAGE_W            6
`define NBI_BLOCK_W           11
// Row bit that selects the plane (overall address bit 18).
`define NBI_PLANE_ROW_BIT     6

// Address cycle layout.
`define NBI_ADDR_CYCLES       5
`define NBI_LAST_ADDR_IDX     3'h4
`define NBI_CNT_W             4

`endif

// file: src/nbi_pkg.sv
package nbi_pkg;

    typedef enum logic [2:0] {
        NBI_KIND_CMD   = 3'h0,
        NBI_KIND_ADDR  = 3'h1,
        NBI_KIND_WDATA = 3'h2,
        NBI_KIND_RDATA = 3'h3,
        NBI_KIND_WAIT  = 3'h4
    } nbi_kind_e;

    typedef enum logic [2:0] {
        NBI_ST_IDLE  = 3'h0,
        NBI_ST_SETUP = 3'h1,
        NBI_ST_WLOW  = 3'h2,
        NBI_ST_WHIGH = 3'h3,
        NBI_ST_RLOW  = 3'h4,
        NBI_ST_RHIGH = 3'h5,
        NBI_ST_WAITB = 3'h6,
        NBI_ST_POLL  = 3'h7
    } nbi_state_e;

    typedef struct packed {
        nbi_state_e  st;
        nbi_kind_e   kind;
        logic [3:0]  cnt;
        logic [2:0]  idx;
        logic [7:0]  wbyte;
        logic [11:0] col;
        logic [16:0] row;
        logic        io_oe_n;
        logic [7:0]  io_out;
        logic        ce_n;
        logic        cle;
        logic        ale;
        logic        we_n;
        logic        re_n;
        logic        wp_n;
        logic        req_ready;
        logic        rsp_valid;
        logic [7:0]  rsp_data;
        logic [7:0]  io_meta;
        logic [7:0]  io_sync;
        logic        rb_meta;
        logic        rb_sync;
    } nbi_state_s;

endpackage : nbi_pkg

// file: src/nbi_host.sv
`timescale 1ns/10ps
`include "nbi_regs.svh"

module nbi_host (
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_b_i,
    input  wire logic                     req_valid_i,
    input  wire nbi_pkg::nbi_kind_e       req_kind_i,
    input  wire logic [7:0]               req_byte_i,
    input  wire logic [`NBI_COL_W-1:0]    req_col_i,
    input  wire logic [`NBI_BLOCK_W-1:0]  req_block_i,
    input  wire logic [`NBI_PAGE_W-1:0]   req_page_i,
    input  wire logic                     protect_i,
    output logic                          req_ready_o,
    output logic                          rsp_valid_o,
    output logic [7:0]                    rsp_data_o,
    output logic                          ce_n_o,
    output logic                          cle_o,
    output logic                          ale_o,
    output logic                          we_n_o,
    output logic                          read_strobe_n_o,
    output logic                          wp_n_o,
    output logic [7:0]                    io_o,
    output logic                          io_oe_n_o,
    input  wire logic [7:0]               io_i,
    input  wire logic                     ready_busy_n_i
);

    nbi_pkg::nbi_state_s s;
    nbi_pkg::nbi_state_s next_s;

    // Byte driven in the current write cycle, taken from the address index.
    function automatic logic [7:0] addr_byte(input logic [2:0]  idx,
                                             input logic [11:0] col,
                                             input logic [16:0] row);
        logic [7:0] b;
        b = 8'h00;
        unique case (idx)
            3'h0: b = col[7:0];
            3'h1: b = {4'h0, col[11:8]};
            3'h2: b = row[7:0];
            3'h3: b = row[15:8];
            default: b = {7'h00, row[16]};
        endcase
        return b;
    endfunction : addr_byte

    always_comb
    begin
        next_s = s;
        next_s.rsp_valid = 1'b0;
        // Pins pass two flip-flops; only the second stage is read by logic.
        next_s.io_meta = io_i;
        next_s.io_sync = s.io_meta;
        next_s.rb_meta = ready_busy_n_i;
        next_s.rb_sync = s.rb_meta;
        next_s.wp_n = ~protect_i;
        if (s.cnt != 4'h0)
        begin
            next_s.cnt = s.cnt - 4'h1;
        end
        unique case (s.st)
            nbi_pkg::NBI_ST_IDLE:
            begin
                if (req_valid_i && s.req_ready)
                begin
                    next_s.req_ready = 1'b0;
                    next_s.kind = req_kind_i;
                    next_s.wbyte = req_byte_i;
                    next_s.col = req_col_i;
                    // Block bit zero lands on the plane bit by this packing.
                    next_s.row = {req_block_i, req_page_i};
                    next_s.idx = 3'h0;
                    if (req_kind_i == nbi_pkg::NBI_KIND_WAIT)
                    begin
                        next_s.st = nbi_pkg::NBI_ST_POLL;
                        next_s.cnt = 4'h0;
                    end
                    else
                    begin
                        next_s.st = nbi_pkg::NBI_ST_SETUP;
                        next_s.cnt = 4'(`NBI_SETUP_CYC - 1);
                        next_s.ce_n = 1'b0;
                        next_s.cle = (req_kind_i == nbi_pkg::NBI_KIND_CMD);
                        next_s.ale = (req_kind_i == nbi_pkg::NBI_KIND_ADDR);
                        if (req_kind_i == nbi_pkg::NBI_KIND_RDATA)
                        begin
                            next_s.io_oe_n = 1'b1;
                        end
                        else
                        begin
                            next_s.io_oe_n = 1'b0;
                            // Opcodes pass unchanged; keeping to defined ones is the requester's duty.
                            next_s.io_out = (req_kind_i == nbi_pkg::NBI_KIND_ADDR)
                                ? addr_byte(3'h0, req_col_i, {req_block_i, req_page_i})
                                : req_byte_i;
                        end
                    end
                end
            end
            nbi_pkg::NBI_ST_SETUP:
            begin
                if (s.cnt == 4'h0)
                begin
                    if (s.kind == nbi_pkg::NBI_KIND_RDATA)
                    begin
                        next_s.st = nbi_pkg::NBI_ST_RLOW;
                        next_s.re_n = 1'b0;
                        next_s.cnt = 4'(`NBI_RLOW_CYC - 1);
                    end
                    else
                    begin
                        next_s.st = nbi_pkg::NBI_ST_WLOW;
                        next_s.we_n = 1'b0;
                        next_s.cnt = 4'(`NBI_WLOW_CYC - 1);
                    end
                end
            end
            nbi_pkg::NBI_ST_WLOW:
            begin
                if (s.cnt == 4'h0)
                begin
                    // The device latches on this rising edge.
                    next_s.st = nbi_pkg::NBI_ST_WHIGH;
                    next_s.we_n = 1'b1;
                    next_s.cnt = 4'(`NBI_WHIGH_CYC - 1);
                end
            end
            nbi_pkg::NBI_ST_WHIGH:
            begin
                if (s.cnt == 4'h0)
                begin
                    // Exactly five address cycles; extras would be ignored anyway.
                    if (s.kind == nbi_pkg::NBI_KIND_ADDR && s.idx != `NBI_LAST_ADDR_IDX)
                    begin
                        next_s.idx = s.idx + 3'h1;
                        next_s.io_out = addr_byte(s.idx + 3'h1, s.col, s.row);
                        next_s.st = nbi_pkg::NBI_ST_SETUP;
                        next_s.cnt = 4'(`NBI_SETUP_CYC - 1);
                    end
                    else
                    begin
                        next_s.st = nbi_pkg::NBI_ST_IDLE;
                        next_s.ce_n = 1'b1;
                        next_s.cle = 1'b0;
                        next_s.ale = 1'b0;
                        next_s.io_oe_n = 1'b1;
                        next_s.req_ready = 1'b1;
                        next_s.rsp_valid = 1'b1;
                        next_s.rsp_data = 8'h00;
                    end
                end
            end
            nbi_pkg::NBI_ST_RLOW:
            begin
                if (s.cnt == 4'h0)
                begin
                    // The low phase already absorbs access time and synchroniser delay.
                    next_s.rsp_data = s.io_sync;
                    next_s.re_n = 1'b1;
                    next_s.st = nbi_pkg::NBI_ST_RHIGH;
                    next_s.cnt = 4'(`NBI_RHIGH_CYC - 1);
                end
            end
            nbi_pkg::NBI_ST_RHIGH:
            begin
                if (s.cnt == 4'h0)
                begin
                    next_s.st = nbi_pkg::NBI_ST_IDLE;
                    next_s.ce_n = 1'b1;
                    next_s.req_ready = 1'b1;
                    next_s.rsp_valid = 1'b1;
                end
            end
            nbi_pkg::NBI_ST_POLL:
            begin
                // Give the device its busy delay before trusting the line.
                next_s.st = nbi_pkg::NBI_ST_WAITB;
                next_s.cnt = 4'(`NBI_WB_CYC - 1);
            end
            nbi_pkg::NBI_ST_WAITB:
            begin
                if (s.cnt == 4'h0 && s.rb_sync)
                begin
                    next_s.st = nbi_pkg::NBI_ST_IDLE;
                    next_s.req_ready = 1'b1;
                    next_s.rsp_valid = 1'b1;
                    next_s.rsp_data = 8'h00;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            s <= '0;
            s.st <= nbi_pkg::NBI_ST_IDLE;
            s.kind <= nbi_pkg::NBI_KIND_CMD;
            s.io_oe_n <= 1'b1;
            s.ce_n <= 1'b1;
            s.we_n <= 1'b1;
            s.re_n <= 1'b1;
            s.req_ready <= 1'b1;
            s.rb_meta <= 1'b1;
            s.rb_sync <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign req_ready_o = s.req_ready;
    assign rsp_valid_o = s.rsp_valid;
    assign rsp_data_o = s.rsp_data;
    assign ce_n_o = s.ce_n;
    assign cle_o = s.cle;
    assign ale_o = s.ale;
    assign we_n_o = s.we_n;
    assign read_strobe_n_o = s.re_n;
    assign wp_n_o = s.wp_n;
    assign io_o = s.io_out;
    assign io_oe_n_o = s.io_oe_n;

endmodule : nbi_host

// file: testbench/nbi_host_checker.sv
`timescale 1ns/10ps
module nbi_host_checker (
    input wire logic               clk_sys_i,
    input wire logic               rst_b_i,
    input wire logic               req_valid_i,
    input wire nbi_pkg::nbi_kind_e req_kind_i,
    input wire logic               protect_i,
    input wire logic               req_ready_o,
    input wire logic               rsp_valid_o,
    input wire logic               ce_n_o,
    input wire logic               cle_o,
    input wire logic               ale_o,
    input wire logic               we_n_o,
    input wire logic               read_strobe_n_o,
    input wire logic               wp_n_o,
    input wire logic               io_oe_n_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    logic take;
    assign take = req_valid_i && req_ready_o;
    a_latch_excl: assert property (!(cle_o && ale_o))
        else $error("command and address latch high together");
    a_write_framed: assert property (!we_n_o |-> !ce_n_o && !io_oe_n_o)
        else $error("write strobe low outside a driven frame");
    a_read_pins: assert property (!read_strobe_n_o |-> !ce_n_o && !ale_o && we_n_o && io_oe_n_o)
        else $error("read strobe low with wrong pin levels");
    a_cmd_answer: assert property (take && req_kind_i == nbi_pkg::NBI_KIND_CMD |-> ##5 rsp_valid_o)
        else $error("command cycle not answered after five cycles");
    a_addr_answer: assert property (take && req_kind_i == nbi_pkg::NBI_KIND_ADDR
        |=> !rsp_valid_o [*8] ##13 rsp_valid_o) else $error("address cycles wrong length");
    a_read_answer: assert property (take && req_kind_i == nbi_pkg::NBI_KIND_RDATA
        |-> ##2 !read_strobe_n_o ##6 rsp_valid_o) else $error("read cycle timing wrong");
    a_busy_wait: assert property (take && req_kind_i == nbi_pkg::NBI_KIND_WAIT
        |=> !rsp_valid_o [*8] ##1 !rsp_valid_o [*2]) else $error("busy wait ended early");
    a_wp_follow: assert property ($past(rst_b_i) |-> wp_n_o == !$past(protect_i))
        else $error("write protect pin does not follow request");
endmodule : nbi_host_checker

bind nbi_host nbi_host_checker u_chk (.clk_sys_i, .rst_b_i, .req_valid_i, .req_kind_i,
    .protect_i, .req_ready_o, .rsp_valid_o, .ce_n_o, .cle_o, .ale_o, .we_n_o,
    .read_strobe_n_o, .wp_n_o, .io_oe_n_o);

// file: testbench/nbi_flash_model.sv
`timescale 1ns/10ps
module nbi_flash_model (
    input  wire logic       ce_n_i,
    input  wire logic       cle_i,
    input  wire logic       ale_i,
    input  wire logic       we_n_i,
    input  wire logic       read_strobe_n_i,
    input  wire logic       wp_n_i,
    input  wire logic [7:0] io_i,
    output logic [7:0]      io_o,
    output logic            io_drive_o,
    output logic            busy_pull_o = 1'b0,
    output logic            addr_err_o = 1'b0,
    output logic [7:0]      last_wr_o = 8'h00
);
    logic [7:0]  cmd = 8'h00;
    logic [39:0] abuf = '0;
    logic [2:0]  idx = 3'h0;
    // Each process owns its own counter, so the live column has a single driver.
    logic [11:0] col0 = 12'h000;
    logic [11:0] n_rd = 12'h000;
    logic [11:0] rd_mark = 12'h000;
    logic [11:0] ptr;
    logic [16:0] row = 17'h00000;
    // Read busy is short and program busy long, so the host sees both a prompt and a slow device.
    task automatic hold_busy(input int ns);
        // Step off the clock edge the strobe rose on, so the release never races sampling.
        #1;
        busy_pull_o = 1'b1;
        #(ns);
        busy_pull_o = 1'b0;
    endtask : hold_busy
    always @(posedge we_n_i)
    begin
        if (!ce_n_i && cle_i)
        begin
            idx = 3'h0;
            if (io_i == 8'h30 && cmd == 8'h00)
            begin
                col0 = abuf[11:0];
                rd_mark = n_rd;
                row = abuf[32:16];
                fork hold_busy(400); join_none
            end
            else if (io_i == 8'h10 && wp_n_i)
                fork hold_busy(1500); join_none
            cmd = io_i;
        end
        else if (!ce_n_i && ale_i && idx < 3'h5)
        begin
            if ((idx == 3'h1 && io_i[7:4] != 4'h0) || (idx == 3'h4 && io_i[7:1] != 7'h0))
                addr_err_o = 1'b1;
            abuf[8*idx +: 8] = io_i;
            idx = idx + 3'h1;
        end
        else if (!ce_n_i && !ale_i)
            last_wr_o = io_i;
    end
    always @(posedge read_strobe_n_i)
        if (!ce_n_i)
            n_rd <= n_rd + 12'h001;
    assign ptr = col0 + n_rd - rd_mark;
    assign io_drive_o = !ce_n_i && !read_strobe_n_i;
    assign io_o = ptr[7:0] ^ {ptr[11:8], 4'h0} ^ row[7:0] ^ row[15:8] ^ {row[16], 7'h0};
endmodule : nbi_flash_model

// file: testbench/tb_nbi_host.sv
`timescale 1ns/10ps
module tb_nbi_host;
    logic clk_sys_i = 1'b0, rst_b_i = 1'b0, req_valid_i = 1'b0, protect_i = 1'b0;
    nbi_pkg::nbi_kind_e req_kind_i = nbi_pkg::NBI_KIND_CMD;
    logic [7:0]  req_byte_i = 8'h00, rsp_data_o, io_o, io_i, m_io, m_last, rd;
    logic [11:0] req_col_i = 12'h000;
    logic [10:0] req_block_i = 11'h000;
    logic [5:0]  req_page_i = 6'h00;
    logic req_ready_o, rsp_valid_o, ce_n_o, cle_o, ale_o, we_n_o, read_strobe_n_o, wp_n_o;
    logic io_oe_n_o, ready_busy_n_i, m_drv, m_busy, m_err;
    int n_fail = 0, num_checks = 0, cyc = 0, lat;
    nbi_host dut (.clk_sys_i, .rst_b_i, .req_valid_i, .req_kind_i, .req_byte_i, .req_col_i,
        .req_block_i, .req_page_i, .protect_i, .req_ready_o, .rsp_valid_o, .rsp_data_o,
        .ce_n_o, .cle_o, .ale_o, .we_n_o, .read_strobe_n_o, .wp_n_o, .io_o, .io_oe_n_o,
        .io_i, .ready_busy_n_i);
    nbi_flash_model m (.ce_n_i(ce_n_o), .cle_i(cle_o), .ale_i(ale_o), .we_n_i(we_n_o),
        .read_strobe_n_i(read_strobe_n_o), .wp_n_i(wp_n_o), .io_i(io_i), .io_o(m_io),
        .io_drive_o(m_drv), .busy_pull_o(m_busy), .addr_err_o(m_err), .last_wr_o(m_last));
    // A released bus shows a changing pattern so stale data is never read as valid.
    assign io_i = !io_oe_n_o ? io_o : (m_drv ? m_io : cyc[7:0]);
    assign ready_busy_n_i = m_busy ? 1'b0 : 1'b1;
    always #5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (n_fail == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : check_byte
    task automatic check_num(input string nm, input int e, input int g);
        check_byte(nm, 8'(e), 8'(g));
    endtask : check_num
    function automatic logic [7:0] exp_byte(input logic [11:0] c, input logic [16:0] r);
        return c[7:0] ^ {c[11:8], 4'h0} ^ r[7:0] ^ r[15:8] ^ {r[16], 7'h0};
    endfunction : exp_byte
    task automatic go(input nbi_pkg::nbi_kind_e kind, input logic [7:0] b);
        @(posedge clk_sys_i);
        #1;
        req_valid_i = 1'b1;
        req_kind_i = kind;
        req_byte_i = b;
        while (req_ready_o !== 1'b1)
        begin
            @(posedge clk_sys_i);
            #1;
        end
        @(posedge clk_sys_i);
        #1;
        req_valid_i = 1'b0;
        // Latency counts from the take edge to the edge that samples the answer.
        lat = 1;
        while (rsp_valid_o !== 1'b1)
        begin
            @(posedge clk_sys_i);
            #1;
            lat++;
        end
        rd = rsp_data_o;
    endtask : go
    task automatic addr(input logic [11:0] c, input logic [10:0] blk, input logic [5:0] pg);
        req_col_i = c;
        req_block_i = blk;
        req_page_i = pg;
        go(nbi_pkg::NBI_KIND_ADDR, 8'h00);
    endtask : addr
    task automatic t_first_read();
        addr(12'h7fe, 11'h5a3, 6'h2d);
        check_num("addr_lat", 21, lat);
        go(nbi_pkg::NBI_KIND_CMD, 8'h30);
        check_num("cmd_lat", 5, lat);
        go(nbi_pkg::NBI_KIND_WAIT, 8'h00);
        check_num("read_busy", 1, int'(lat > 25));
        for (int k = 0; k < 3; k++)
        begin
            go(nbi_pkg::NBI_KIND_RDATA, 8'h00);
            check_byte("rdata", exp_byte(12'h7fe + 12'(k), {11'h5a3, 6'h2d}), rd);
        end
        check_num("rd_lat", 8, lat);
        check_byte("addr_err", 8'h00, {7'h00, m_err});
    endtask : t_first_read
    task automatic t_extra_addr();
        go(nbi_pkg::NBI_KIND_CMD, 8'h00);
        addr(12'h013, 11'h001, 6'h3f);
        addr(12'hfff, 11'h7fe, 6'h00);
        go(nbi_pkg::NBI_KIND_CMD, 8'h30);
        go(nbi_pkg::NBI_KIND_WAIT, 8'h00);
        go(nbi_pkg::NBI_KIND_RDATA, 8'h00);
        check_byte("plane_rdata", exp_byte(12'h013, {11'h001, 6'h3f}), rd);
    endtask : t_extra_addr
    task automatic program_page(input logic [7:0] b);
        go(nbi_pkg::NBI_KIND_CMD, 8'h80);
        addr(12'h000, 11'h002, 6'h01);
        go(nbi_pkg::NBI_KIND_WDATA, b);
        check_byte("wdata", b, m_last);
        go(nbi_pkg::NBI_KIND_CMD, 8'h10);
        go(nbi_pkg::NBI_KIND_WAIT, 8'h00);
    endtask : program_page
    task automatic t_protect();
        protect_i = 1'b1;
        program_page(8'h3c);
        check_num("refused_busy", 1, int'(lat < 20));
        protect_i = 1'b0;
        program_page(8'hc3);
        check_num("program_busy", 1, int'(lat > 100));
    endtask : t_protect
    initial
    begin
        repeat (6) @(posedge clk_sys_i);
        #1;
        check_byte("rst_pins", 8'h9b, {ce_n_o, cle_o, ale_o, we_n_o, read_strobe_n_o, wp_n_o,
            io_oe_n_o, req_ready_o});
        rst_b_i = 1'b1;
        t_first_read();
        t_extra_addr();
        t_protect();
        give_verdict();
    end
endmodule : tb_nbi_host
